// *** scg_defs.svh ***
// Register indices, field positions, reset values and timing counts of the clock generator
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define SCG_IDX_GATE_A     9'h063
`define SCG_IDX_GATE_B     9'h064
`define SCG_IDX_GATE_C     9'h065
`define SCG_IDX_SYS_SEL    9'h066
`define SCG_IDX_I2S_STEP   9'h067
`define SCG_IDX_I2S_MOD    9'h068
`define SCG_IDX_CODEC_STEP 9'h06c
`define SCG_IDX_CODEC_MOD  9'h06d
`define SCG_IDX_FAST_HIGH  9'h070
`define SCG_IDX_STATUS     9'h071

// ****************************************
// Reset values
// ****************************************
`define SCG_RST_GATE_A     8'h83
`define SCG_RST_GATE_B     8'h00
`define SCG_RST_GATE_C     8'h30
`define SCG_RST_SYS_SEL    8'h06
`define SCG_RST_I2S_STEP   8'h00
`define SCG_RST_I2S_MOD    8'h02
`define SCG_RST_CODEC_STEP 8'h01
`define SCG_RST_CODEC_MOD  8'h02
`define SCG_RST_FAST_HIGH  8'h00

// ****************************************
// Field positions
// ****************************************
`define SCG_SEL_DIV_MSB    4
`define SCG_SEL_DIV_LSB    0
`define SCG_SEL_SRC_MSB    6
`define SCG_SEL_SRC_LSB    5
`define SCG_SEL_FAST_LO    7
`define SCG_FAST_HI_BIT    0
`define SCG_STEP_EN_BIT    7
`define SCG_STEP_MSB       6
`define SCG_GATE_USB_BIT   3
`define SCG_GATE_TIMER_BIT 9

// ****************************************
// Timing counts: two of every three ticks pass
// ****************************************
`define SCG_THIRDS_LAST    2'h2

`endif

// *** scg_pkg.sv ***
// Types shared by the clock generator modules
package scg_pkg;

  // ****************************************
  // Source clock ticks, one-cycle enables
  // ****************************************
  typedef struct packed {
    logic rc;
    logic pad;
    logic dbl;
  } scg_src_ticks_t;

  typedef enum logic [1:0] {
    SCG_SRC_RC    = 2'h0,
    SCG_SRC_FAST  = 2'h1,
    SCG_SRC_DIV   = 2'h2,
    SCG_SRC_32M   = 2'h3
  } scg_sys_src_t;

  typedef enum logic [1:0] {
    SCG_SW_RUN   = 2'h0,
    SCG_SW_HOLD  = 2'h1,
    SCG_SW_ALIGN = 2'h3
  } scg_sw_state_t;

endpackage : scg_pkg

// *** scg_frac_div.sv ***
// Step/mod fractional divider producing a toggling clock level
module scg_frac_div
  import scg_pkg::*;
#(
  parameter int STEP_W = 7,
  parameter int MOD_W  = 8
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // Control
  input  wire logic              tick,
  input  wire logic              enable,
  input  wire logic [STEP_W-1:0] step,
  input  wire logic [MOD_W-1:0]  modulus,
  // Output
  output logic                   clk_out
);

  initial begin
    if (MOD_W <= STEP_W) $error("scg_frac_div: MOD_W must exceed STEP_W");
  end

  logic [MOD_W:0] acc;
  logic [MOD_W:0] sum;

  // Twice the step per tick so each toggle pair forms one period
  assign sum = acc + {{(MOD_W-STEP_W){1'b0}}, step, 1'b0};

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      acc     <= '0;
      clk_out <= 1'b0;
    end else if (!enable || modulus == '0) begin
      acc     <= '0;
      clk_out <= 1'b0;
    end else if (tick) begin
      if (sum >= {1'b0, modulus}) begin
        acc     <= sum - {1'b0, modulus};
        clk_out <= ~clk_out;
      end else begin
        acc <= sum;
      end
    end
  end

endmodule : scg_frac_div

// *** scg_top.sv ***
// System clock generator: source select, divider, module gates, audio dividers
`include "scg_defs.svh"

module scg_top
  import scg_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           reset,
  // Avalon-MM register slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic           read,
  input  wire logic           write,
  input  wire logic [31:0]    writedata,
  input  wire logic [3:0]     byteenable,
  output logic      [31:0]    readdata,
  output logic                waitrequest,
  // Source clock ticks
  input  wire scg_src_ticks_t src_ticks,
  // Generated clock enables and levels
  output logic                sys_clk_tick,
  output logic                fast_source_clock_tick,
  output logic      [23:0]    module_clock_gates_tick,
  output logic                timer_clk_tick,
  output logic                usb_clk_tick,
  output logic                i2s_clk,
  output logic                codec_clk,
  output logic                switch_busy
);

  initial begin
    if (ADDR_W < 11) $error("scg_top: ADDR_W must be at least 11");
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] module_clock_gate_a;
  logic [7:0] module_clock_gate_b;
  logic [7:0] module_clock_gate_c;
  logic [7:0] system_clock_select;
  logic [7:0] serial_audio_clock_step;
  logic [7:0] serial_audio_clock_mod;
  logic [7:0] codec_clock_step;
  logic [7:0] codec_clock_mod;
  logic [7:0] fast_clock_source_high;
  logic [8:0] reg_index;
  logic       req;
  logic       wr_now;
  scg_sw_state_t sw_state;

  assign reg_index = address[10:2];
  assign req       = read || write;
  assign wr_now    = write && !waitrequest && byteenable[0];

  function automatic logic [7:0] reg_read(input logic [8:0] idx);
    case (idx)
      `SCG_IDX_GATE_A:     reg_read = module_clock_gate_a;
      `SCG_IDX_GATE_B:     reg_read = module_clock_gate_b;
      `SCG_IDX_GATE_C:     reg_read = module_clock_gate_c;
      `SCG_IDX_SYS_SEL:    reg_read = system_clock_select;
      `SCG_IDX_I2S_STEP:   reg_read = serial_audio_clock_step;
      `SCG_IDX_I2S_MOD:    reg_read = serial_audio_clock_mod;
      `SCG_IDX_CODEC_STEP: reg_read = codec_clock_step;
      `SCG_IDX_CODEC_MOD:  reg_read = codec_clock_mod;
      `SCG_IDX_FAST_HIGH:  reg_read = fast_clock_source_high;
      `SCG_IDX_STATUS:     reg_read = {6'h00, sw_state};
      default:             reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // One wait cycle, then a single ready cycle per request
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(req && waitrequest);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= {24'h00_0000, reg_read(reg_index)};
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      module_clock_gate_a     <= `SCG_RST_GATE_A;
      module_clock_gate_b     <= `SCG_RST_GATE_B;
      module_clock_gate_c     <= `SCG_RST_GATE_C;
      system_clock_select     <= `SCG_RST_SYS_SEL;
      serial_audio_clock_step <= `SCG_RST_I2S_STEP;
      serial_audio_clock_mod  <= `SCG_RST_I2S_MOD;
      codec_clock_step        <= `SCG_RST_CODEC_STEP;
      codec_clock_mod         <= `SCG_RST_CODEC_MOD;
      fast_clock_source_high  <= `SCG_RST_FAST_HIGH;
    end else if (wr_now) begin
      case (reg_index)
        `SCG_IDX_GATE_A:     module_clock_gate_a     <= writedata[7:0];
        `SCG_IDX_GATE_B:     module_clock_gate_b     <= writedata[7:0];
        `SCG_IDX_GATE_C:     module_clock_gate_c     <= writedata[7:0];
        `SCG_IDX_SYS_SEL:    system_clock_select     <= writedata[7:0];
        `SCG_IDX_I2S_STEP:   serial_audio_clock_step <= writedata[7:0];
        `SCG_IDX_I2S_MOD:    serial_audio_clock_mod  <= writedata[7:0];
        `SCG_IDX_CODEC_STEP: codec_clock_step        <= writedata[7:0];
        `SCG_IDX_CODEC_MOD:  codec_clock_mod         <= writedata[7:0];
        `SCG_IDX_FAST_HIGH:  fast_clock_source_high  <= writedata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Two-of-three pass counters
  // ****************************************
  function automatic logic [1:0] thirds_next(input logic [1:0] cnt);
    thirds_next = (cnt == `SCG_THIRDS_LAST) ? 2'h0 : cnt + 2'h1;
  endfunction : thirds_next

  logic [1:0] dbl_thirds;
  logic [1:0] pad_thirds;
  logic       pass_32m;
  logic       pass_16m;

  assign pass_32m = src_ticks.dbl && dbl_thirds != `SCG_THIRDS_LAST;
  assign pass_16m = src_ticks.pad && pad_thirds != `SCG_THIRDS_LAST;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dbl_thirds <= 2'h0;
      pad_thirds <= 2'h0;
    end else begin
      if (src_ticks.dbl) dbl_thirds <= thirds_next(dbl_thirds);
      if (src_ticks.pad) pad_thirds <= thirds_next(pad_thirds);
    end
  end

  // ****************************************
  // Fast source and system source selection
  // ****************************************
  logic [1:0]   fast_code;
  logic         fast_tick;
  logic [4:0]   div_value;
  scg_sys_src_t sys_src;

  assign fast_code = {fast_clock_source_high[`SCG_FAST_HI_BIT],
                      system_clock_select[`SCG_SEL_FAST_LO]};
  assign div_value = system_clock_select[`SCG_SEL_DIV_MSB:`SCG_SEL_DIV_LSB];
  assign sys_src   = scg_sys_src_t'(system_clock_select[`SCG_SEL_SRC_MSB:`SCG_SEL_SRC_LSB]);

  always_comb begin
    case (fast_code)
      2'h0:    fast_tick = src_ticks.dbl;
      2'h1:    fast_tick = src_ticks.rc;
      default: fast_tick = src_ticks.pad;
    endcase
  end

  // ****************************************
  // Glitch-free switching and fast divider
  // ****************************************
  logic [8:0] cfg_seen;
  logic       cfg_changed;
  logic [4:0] div_count;
  logic       div_pulse;
  logic       raw_tick;

  assign cfg_changed = {fast_code[1], system_clock_select} != cfg_seen;
  assign div_pulse   = fast_tick && div_count == div_value - 5'h01;

  always_comb begin
    case (sys_src)
      SCG_SRC_RC:   raw_tick = src_ticks.rc;
      SCG_SRC_FAST: raw_tick = fast_tick;
      SCG_SRC_DIV:  raw_tick = div_pulse;
      SCG_SRC_32M:  raw_tick = pass_32m;
      default:      raw_tick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_seen <= {1'b0, `SCG_RST_SYS_SEL};
    end else begin
      cfg_seen <= {fast_code[1], system_clock_select};
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sw_state <= SCG_SW_RUN;
    end else begin
      case (sw_state)
        SCG_SW_RUN:   if (cfg_changed) sw_state <= SCG_SW_HOLD;
        SCG_SW_HOLD:  sw_state <= cfg_changed ? SCG_SW_HOLD : SCG_SW_ALIGN;
        SCG_SW_ALIGN: begin
          if (cfg_changed) begin
            sw_state <= SCG_SW_HOLD;
          end else if (raw_tick) begin
            sw_state <= SCG_SW_RUN;
          end
        end
        default:      sw_state <= SCG_SW_HOLD;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_count <= 5'h00;
    end else if (sw_state == SCG_SW_HOLD || cfg_changed) begin
      div_count <= 5'h00;
    end else if (fast_tick) begin
      div_count <= div_pulse ? 5'h00 : div_count + 5'h01;
    end
  end

  // ****************************************
  // Output enables, all registered
  // ****************************************
  logic [23:0] gates;
  logic [23:0] gate_src;
  logic        next_sys_tick;

  assign next_sys_tick = sw_state == SCG_SW_RUN && !cfg_changed && raw_tick;
  assign gates = {module_clock_gate_c, module_clock_gate_b, module_clock_gate_a};

  always_comb begin
    gate_src                      = {24{next_sys_tick}};
    gate_src[`SCG_GATE_USB_BIT]   = src_ticks.dbl;
    gate_src[`SCG_GATE_TIMER_BIT] = pass_16m;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sys_clk_tick            <= 1'b0;
      fast_source_clock_tick  <= 1'b0;
      module_clock_gates_tick <= 24'h00_0000;
      timer_clk_tick          <= 1'b0;
      usb_clk_tick            <= 1'b0;
      switch_busy             <= 1'b0;
    end else begin
      sys_clk_tick            <= next_sys_tick;
      fast_source_clock_tick  <= fast_tick;
      module_clock_gates_tick <= gates & gate_src;
      timer_clk_tick          <= pass_16m;
      usb_clk_tick            <= src_ticks.dbl;
      switch_busy             <= sw_state != SCG_SW_RUN || cfg_changed;
    end
  end

  // ****************************************
  // Audio fractional dividers
  // ****************************************
  scg_frac_div #(
    .STEP_W (7),
    .MOD_W  (8)
  ) u_i2s_div (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (src_ticks.dbl),
    .enable  (serial_audio_clock_step[`SCG_STEP_EN_BIT]),
    .step    (serial_audio_clock_step[`SCG_STEP_MSB:0]),
    .modulus (serial_audio_clock_mod),
    .clk_out (i2s_clk)
  );

  scg_frac_div #(
    .STEP_W (7),
    .MOD_W  (8)
  ) u_codec_div (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (src_ticks.dbl),
    .enable  (codec_clock_step[`SCG_STEP_EN_BIT]),
    .step    (codec_clock_step[`SCG_STEP_MSB:0]),
    .modulus (codec_clock_mod),
    .clk_out (codec_clk)
  );

endmodule : scg_top

// *** scg_top_chk.sv ***
// Port-level assertion checker for the system clock generator
`include "scg_defs.svh"
module scg_top_chk
  import scg_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  // Clock, reset and bus
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic              write,
  input wire logic [31:0]       writedata,
  input wire logic [3:0]        byteenable,
  input wire logic              waitrequest,
  // Sources and generated clocks
  input wire scg_src_ticks_t    src_ticks,
  input wire logic              sys_clk_tick,
  input wire logic [23:0]       module_clock_gates_tick,
  input wire logic              timer_clk_tick,
  input wire logic              usb_clk_tick,
  input wire logic              i2s_clk,
  input wire logic              codec_clk,
  input wire logic              switch_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sel;
  logic [7:0] gate_a;
  logic       i2s_en;
  logic       codec_en;
  // ****************************************
  // Shadow of written control fields
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sel      <= 8'h06;
      gate_a   <= 8'h83;
      i2s_en   <= 1'b0;
      codec_en <= 1'b0;
    end else if (write && !waitrequest && byteenable[0]) begin
      case (address[10:2])
        `SCG_IDX_SYS_SEL:    sel <= writedata[7:0];
        `SCG_IDX_GATE_A:     gate_a <= writedata[7:0];
        `SCG_IDX_I2S_STEP:   i2s_en <= writedata[7];
        `SCG_IDX_CODEC_STEP: codec_en <= writedata[7];
        default: ;
      endcase
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  a_usb_follows_dbl: assert property (
    !$past(reset) |-> usb_clk_tick == $past(src_ticks.dbl)) else $error("usb tick mismatch");
  a_gate_usb_bit: assert property (
    !$past(reset) |-> module_clock_gates_tick[3] == ($past(src_ticks.dbl) && $past(gate_a[3])))
    else $error("gated usb tick mismatch");
  a_gate_off_blocks: assert property (
    !$past(gate_a[0]) |-> !module_clock_gates_tick[0]) else $error("closed gate passed a tick");
  a_gate_pass_sys: assert property (
    module_clock_gates_tick[0] == ($past(gate_a[0]) && sys_clk_tick))
    else $error("gated system tick mismatch");
  a_timer_from_pad: assert property (
    timer_clk_tick |-> $past(src_ticks.pad)) else $error("timer tick without pad tick");
  a_busy_no_tick: assert property (
    switch_busy && $past(switch_busy) |-> !sys_clk_tick) else $error("tick while switching");
  a_rc_source_tick: assert property (
    sys_clk_tick && sel[6:5] == 2'b00 && $stable(sel) && !switch_busy && !$past(switch_busy)
    |-> $past(src_ticks.rc)) else $error("rc mode tick without rc tick");
  a_32m_source_tick: assert property (
    sys_clk_tick && sel[6:5] == 2'b11 && $stable(sel) && !switch_busy && !$past(switch_busy)
    |-> $past(src_ticks.dbl)) else $error("32M mode tick without doubled tick");
  a_audio_off_low: assert property (
    !i2s_en && !$past(i2s_en) && !$past(i2s_en, 2) |-> !i2s_clk) else $error("i2s clock runs");
  a_codec_off_low: assert property (
    !codec_en && !$past(codec_en) && !$past(codec_en, 2) |-> !codec_clk)
    else $error("codec clock runs");
endmodule : scg_top_chk

bind scg_top scg_top_chk #(.ADDR_W(ADDR_W)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .address(address), .write(write),
  .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .src_ticks(src_ticks), .sys_clk_tick(sys_clk_tick),
  .module_clock_gates_tick(module_clock_gates_tick), .timer_clk_tick(timer_clk_tick),
  .usb_clk_tick(usb_clk_tick), .i2s_clk(i2s_clk), .codec_clk(codec_clk),
  .switch_busy(switch_busy));

// *** scg_periph_model.sv ***
// Source oscillator ticks and clock-consuming peripheral model
module scg_periph_model
  import scg_pkg::*;
(
  // Clock and counter clear
  input  wire logic       sys_clk,
  input  wire logic       clr,
  // Clocks consumed
  input  wire logic [7:0] taps,
  // Source ticks and edge counts
  output scg_src_ticks_t  src_ticks,
  output logic [7:0][15:0] cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase = 2'h0;
  logic [7:0] prev  = 8'h00;
  // ****************************************
  // Free-running sources: doubled every 2, RC and pad every 4
  // ****************************************
  always_ff @(posedge sys_clk) begin
    phase <= phase + 2'h1;
  end
  assign src_ticks = '{rc: (phase == 2'h0), pad: (phase == 2'h2), dbl: phase[0]};
  // Rising edges of each consumed clock
  always_ff @(posedge sys_clk) begin
    prev <= taps;
    for (int i = 0; i < 8; i++) begin
      if (clr) cnt[i] <= 16'h0;
      else if (taps[i] && !prev[i]) cnt[i] <= cnt[i] + 16'h1;
    end
  end
endmodule : scg_periph_model

// *** tb.sv ***
// Self-checking testbench for the system clock generator
module tb
  import scg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 744;
  logic        sys_clk    = 1'b0;
  logic        reset      = 1'b1;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic [10:0] address    = 11'h0;
  logic [31:0] writedata  = 32'h0;
  logic [3:0]  byteenable = 4'h1;
  logic        clr        = 1'b0;
  logic [31:0] readdata;
  logic [23:0] gates;
  logic        waitrequest, sys_clk_tick, fast_tick, timer_tick, usb_tick;
  logic        i2s_clk, codec_clk, switch_busy;
  logic [7:0][15:0] cnt;
  scg_src_ticks_t   src_ticks;
  int          num_errors      = 0;
  int          samples_checked = 0;
  logic [8:0]  rst_idx [11] = '{9'h063, 9'h064, 9'h065, 9'h066, 9'h067, 9'h068, 9'h06c,
                                9'h06d, 9'h070, 9'h069, 9'h071};
  logic [7:0]  rst_val [11] = '{8'h83, 8'h00, 8'h30, 8'h06, 8'h00, 8'h02, 8'h01, 8'h02,
                                8'h00, 8'h00, 8'h00};
  // Fast high bit, select value, expected system and fast tick counts
  int          rows [10][4] = '{'{0, 'h20, 372, 372}, '{0, 'ha0, 186, 186},
    '{1, 'h20, 186, 186}, '{1, 'ha0, 186, 186}, '{0, 'h43, 124, 372}, '{0, 'h42, 186, 372},
    '{0, 'h5f, 12, 372}, '{0, 'h60, 248, 372}, '{0, 'h00, 186, 372}, '{1, 'hc3, 62, 186}};
  always #5 sys_clk = ~sys_clk;
  scg_top #(.ADDR_W(11)) DUT (
    .sys_clk(sys_clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .src_ticks(src_ticks), .sys_clk_tick(sys_clk_tick),
    .fast_source_clock_tick(fast_tick), .module_clock_gates_tick(gates),
    .timer_clk_tick(timer_tick), .usb_clk_tick(usb_tick), .i2s_clk(i2s_clk),
    .codec_clk(codec_clk), .switch_busy(switch_busy));
  scg_periph_model u_periph (.sys_clk(sys_clk), .clr(clr), .src_ticks(src_ticks), .cnt(cnt),
    .taps({codec_clk, i2s_clk, usb_tick, timer_tick, gates[9], gates[3], fast_tick,
           sys_clk_tick}));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input int exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [8:0] idx, input logic [7:0] d, input int exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    address   <= {idx, 2'b00};
    write     <= wr;
    read      <= !wr;
    writedata <= {24'h0, d};
    @(posedge sys_clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    write <= 1'b0;
    read  <= 1'b0;
    if (n == 50) chk("bus answer", 0, 1);
    if (!wr) chk("readdata", exp, readdata);
  endtask : acc
  // Counts over W cycles: sys, fast, gated usb, gated timer, timer, usb, i2s, codec
  task automatic win(input int e [8]);
    int n;
    n = 0;
    @(posedge sys_clk);
    while (switch_busy !== 1'b0 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 300) chk("switch settle", 0, 1);
    repeat (8) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (W) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 8; i++) if (e[i] >= 0) chk("clock count", e[i], {16'h0, cnt[i]});
  endtask : win
  task automatic print_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    acc(1'b1, 9'h069, 8'hff, 0);
    byteenable <= 4'h0;
    acc(1'b1, 9'h070, 8'h01, 0);
    byteenable <= 4'h1;
    foreach (rst_idx[i]) acc(1'b0, rst_idx[i], 8'h00, int'(rst_val[i]));
    win('{186, 372, 0, 0, 124, 372, 0, 0});
    foreach (rows[i]) begin
      acc(1'b1, 9'h070, 8'(rows[i][0]), 0);
      acc(1'b1, 9'h066, 8'(rows[i][1]), 0);
      acc(1'b0, 9'h066, 8'h00, rows[i][1]);
      win('{rows[i][2], rows[i][3], -1, -1, 124, 372, -1, -1});
    end
    acc(1'b1, 9'h063, 8'h08, 0);
    acc(1'b1, 9'h064, 8'h02, 0);
    acc(1'b1, 9'h068, 8'h20, 0);
    acc(1'b1, 9'h067, 8'h88, 0);
    acc(1'b1, 9'h06d, 8'h1e, 0);
    acc(1'b1, 9'h06c, 8'h85, 0);
    win('{-1, -1, 372, 124, -1, -1, 93, 62});
    acc(1'b1, 9'h063, 8'h00, 0);
    acc(1'b1, 9'h067, 8'h08, 0);
    acc(1'b1, 9'h06c, 8'h05, 0);
    win('{-1, -1, 0, 124, -1, -1, 0, 0});
    print_verdict();
  end
  // Watchdog
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule : tb
